// *** acpl_params.svh ***
// register indices, field positions, reset values and counts of the audio clock tree
`ifndef ACPL_PARAMS_SVH
`define ACPL_PARAMS_SVH
`define ACPL_IDX_ROOT_SEL      8'h04
`define ACPL_IDX_PLL_CTRL      8'h05
`define ACPL_IDX_PLL_INT       8'h06
`define ACPL_IDX_PLL_FRAC_HI   8'h07
`define ACPL_IDX_PLL_FRAC_LO   8'h08
`define ACPL_IDX_PREDIV        8'h0b
`define ACPL_IDX_MODDIV        8'h0c
`define ACPL_IDX_OSR_HI        8'h0d
`define ACPL_IDX_OSR_LO        8'h0e
`define ACPL_IDX_GP_SEL        8'h19
`define ACPL_IDX_GP_DIV        8'h1a
`define ACPL_IDX_IF_CTRL       8'h1b
`define ACPL_IDX_BCLK_SEL      8'h1d
`define ACPL_IDX_BCLK_DIV      8'h1e
`define ACPL_IDX_PWR_STAT      8'h25
`define ACPL_IDX_DAC_PWR       8'h40
`define ACPL_BIT_ENABLE        7
`define ACPL_BIT_BCLK_DRIVE    3
`define ACPL_BIT_GP_DRIVE      7
`define ACPL_BIT_STAT_DAC      7
`define ACPL_BIT_STAT_MOD      3
`define ACPL_RST_ROOT_SEL      8'h00
`define ACPL_RST_PLL_CTRL      8'h11
`define ACPL_RST_PLL_INT       8'h04
`define ACPL_RST_OSR_HI        8'h00
`define ACPL_RST_OSR_LO        8'h80
`define ACPL_RST_DIV           8'h01
`define ACPL_FRAC_SCALE        32'd10000
`define ACPL_DRAIN_TICKS       10'h040
`endif

// *** acpl_pkg.sv ***
// types shared by the audio clock tree
`default_nettype none
package acpl_pkg;
    typedef enum logic [1:0] {ACPL_ROOT_MCLK = 2'h0, ACPL_ROOT_BCLK = 2'h1,
                              ACPL_ROOT_GPIO = 2'h2, ACPL_ROOT_PLL = 2'h3} acpl_root_e;
    typedef enum logic [2:0] {ACPL_PWR_OFF = 3'b001, ACPL_PWR_ON = 3'b010,
                              ACPL_PWR_DRAIN = 3'b100} acpl_pwr_e;
    typedef logic [7:0] acpl_reg_t;
endpackage
`default_nettype wire

// *** acpl_clock_tree.sv ***
// clock tree of the mono audio dac: root mux, fractional synth, dividers, pin clock outputs
//
// Behaviour
// - two-bit field picks root audio clock
// - modulator = root/(pre*mod); rate = modulator/osr
// - predivider and modulator divider in seven bits
// - ten-bit oversampling ratio from two registers
// - divider enable bits gate divider clocks
// - shutdown sequence reported in two status flags
// - interface bit makes bit clock pin driven
// - bit clock divides source by 1..128
// - bit clock source: processing or modulator clock
// - general pin one drives divided clock
// - three-bit field picks general clock source
// - synth runs only while enable set
// - synth output = in*R*J.D/P
// - pre-divide P, 1..8, default 1
// - multiply R, 1..16, default 1
// - integer J, 1..63, default 4
// - fraction D fourteen bits, default zero
// - fraction applied after low register write
`timescale 1ns/1ps
`default_nettype none
`include "acpl_params.svh"

module acpl_clock_tree #(
    parameter int DIVW = 10
) (
    // system
    input  wire logic                   ref_clk,
    input  wire logic                   reset,
    // apb slave
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [11:0]            paddr,
    input  wire logic [31:0]            pwdata,
    output logic                        pready,
    output logic [31:0]                 prdata,
    output logic                        pslverr,
    // reference clock pins
    input  wire logic                   mclk_pin,
    input  wire logic                   bclk_in,
    output logic                        bclk_out,
    output logic                        bclk_oe_n,
    input  wire logic                   general_io_pin_one_in,
    output logic                        general_io_pin_one_out,
    output logic                        general_io_pin_one_oe_n,
    // derived clocks as ref_clk pulses, and the dac power level
    output logic                        root_audio_tick,
    output logic                        modulator_clock_tick,
    output logic                        sample_rate_tick,
    output logic                        dac_powered
);
    import acpl_pkg::*;

    initial begin
        if (DIVW < 10) $error("DIVW must hold the ten-bit oversampling ratio");
    end
    localparam int ND = 5; // 0 predivider, 1 modulator, 2 osr, 3 bit clock, 4 general
    acpl_reg_t root_clock_select, pll_enable_predivide_multiply, pll_integer_part;
    acpl_reg_t pll_fraction_high, pll_fraction_low, pll_fraction_shadow;
    acpl_reg_t dac_predivider_ctrl, modulator_divider_ctrl;
    acpl_reg_t oversampling_ratio_high, oversampling_ratio_low;
    acpl_reg_t gp_clock_source_select, gp_clock_divider, bit_clock_divider;
    acpl_reg_t audio_if_ctrl, bclk_source_select, dac_power_ctrl;
    acpl_pwr_e pwr_state;
    logic [9:0] drain_cnt;
    logic       access;
    logic       wr_en;
    logic [7:0] idx;
    logic       mapped;
    logic [7:0] rd_val;
    logic [7:0] pwr_status;

    assign access = psel && penable && pready;
    assign wr_en  = access && pwrite && mapped;
    assign idx    = paddr[9:2];

    // one wait state: pready rises in the second access cycle
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
        end
    end

    always_comb begin
        mapped = 1'b1;
        rd_val = 8'h00;
        case (idx)
            `ACPL_IDX_ROOT_SEL:    rd_val = root_clock_select;
            `ACPL_IDX_PLL_CTRL:    rd_val = pll_enable_predivide_multiply;
            `ACPL_IDX_PLL_INT:     rd_val = pll_integer_part;
            `ACPL_IDX_PLL_FRAC_HI: rd_val = pll_fraction_shadow;
            `ACPL_IDX_PLL_FRAC_LO: rd_val = pll_fraction_low;
            `ACPL_IDX_PREDIV:      rd_val = dac_predivider_ctrl;
            `ACPL_IDX_MODDIV:      rd_val = modulator_divider_ctrl;
            `ACPL_IDX_OSR_HI:      rd_val = oversampling_ratio_high;
            `ACPL_IDX_OSR_LO:      rd_val = oversampling_ratio_low;
            `ACPL_IDX_GP_SEL:      rd_val = gp_clock_source_select;
            `ACPL_IDX_GP_DIV:      rd_val = gp_clock_divider;
            `ACPL_IDX_IF_CTRL:     rd_val = audio_if_ctrl;
            `ACPL_IDX_BCLK_SEL:    rd_val = bclk_source_select;
            `ACPL_IDX_BCLK_DIV:    rd_val = bit_clock_divider;
            `ACPL_IDX_PWR_STAT:    rd_val = pwr_status;
            `ACPL_IDX_DAC_PWR:     rd_val = dac_power_ctrl;
            default:               mapped = 1'b0;
        endcase
        if (paddr[11:10] != 2'b00) begin
            mapped = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            if (psel && penable && !pready) begin
                prdata  <= (pwrite || !mapped) ? 32'h0000_0000 : {24'h00_0000, rd_val};
                pslverr <= !mapped;
            end
        end
    end

    // the high fraction byte waits in a shadow until the low byte lands
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            root_clock_select             <= `ACPL_RST_ROOT_SEL;
            pll_enable_predivide_multiply <= `ACPL_RST_PLL_CTRL;
            pll_integer_part              <= `ACPL_RST_PLL_INT;
            pll_fraction_shadow           <= 8'h00;
            pll_fraction_high             <= 8'h00;
            pll_fraction_low              <= 8'h00;
            dac_predivider_ctrl           <= `ACPL_RST_DIV;
            modulator_divider_ctrl        <= `ACPL_RST_DIV;
            oversampling_ratio_high       <= `ACPL_RST_OSR_HI;
            oversampling_ratio_low        <= `ACPL_RST_OSR_LO;
            gp_clock_source_select        <= 8'h00;
            gp_clock_divider              <= `ACPL_RST_DIV;
            audio_if_ctrl                 <= 8'h00;
            bclk_source_select            <= 8'h00;
            bit_clock_divider             <= `ACPL_RST_DIV;
            dac_power_ctrl                <= 8'h00;
        end else if (wr_en) begin
            case (idx)
                `ACPL_IDX_ROOT_SEL:    root_clock_select <= {4'h0, pwdata[3:0]};
                `ACPL_IDX_PLL_CTRL:    pll_enable_predivide_multiply <= pwdata[7:0];
                `ACPL_IDX_PLL_INT:     pll_integer_part <= {2'b00, pwdata[5:0]};
                `ACPL_IDX_PLL_FRAC_HI: pll_fraction_shadow <= {2'b00, pwdata[5:0]};
                `ACPL_IDX_PLL_FRAC_LO: begin
                    pll_fraction_low  <= pwdata[7:0];
                    pll_fraction_high <= pll_fraction_shadow;
                end
                `ACPL_IDX_PREDIV:      dac_predivider_ctrl <= pwdata[7:0];
                `ACPL_IDX_MODDIV:      modulator_divider_ctrl <= pwdata[7:0];
                `ACPL_IDX_OSR_HI:      oversampling_ratio_high <= {6'h00, pwdata[1:0]};
                `ACPL_IDX_OSR_LO:      oversampling_ratio_low <= pwdata[7:0];
                `ACPL_IDX_GP_SEL:      gp_clock_source_select <= {pwdata[7], 4'h0, pwdata[2:0]};
                `ACPL_IDX_GP_DIV:      gp_clock_divider <= pwdata[7:0];
                `ACPL_IDX_IF_CTRL:     audio_if_ctrl <= pwdata[7:0];
                `ACPL_IDX_BCLK_SEL:    bclk_source_select <= {6'h00, pwdata[1:0]};
                `ACPL_IDX_BCLK_DIV:    bit_clock_divider <= pwdata[7:0];
                `ACPL_IDX_DAC_PWR:     dac_power_ctrl <= {7'h00, pwdata[0]};
                default: ;
            endcase
        end
    end
    logic [2:0] mclk_sync, bclk_sync, gpio_sync;

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mclk_sync <= 3'h0;
            bclk_sync <= 3'h0;
            gpio_sync <= 3'h0;
        end else begin
            mclk_sync <= {mclk_sync[1:0], mclk_pin};
            bclk_sync <= {bclk_sync[1:0], bclk_in};
            gpio_sync <= {gpio_sync[1:0], general_io_pin_one_in};
        end
    end

    // edges are judged on stages two and three only
    logic mclk_rise, bclk_rise, gpio_rise;
    assign mclk_rise = mclk_sync[1] && !mclk_sync[2];
    assign bclk_rise = bclk_sync[1] && !bclk_sync[2] && bclk_oe_n;
    assign gpio_rise = gpio_sync[1] && !gpio_sync[2] && general_io_pin_one_oe_n;
    // credit model: each input edge earns R*J.D, each output tick spends P;
    // output rate is capped at ref_clk, so it stands for the real loop only below that
    logic        synth_input_clock;
    logic        pll_tick;
    logic [31:0] pll_credit;
    logic [31:0] pll_gain;
    logic [31:0] pll_cost;
    logic [4:0]  pll_r;
    logic [3:0]  pll_p;
    logic [13:0] pll_frac;

    always_comb begin
        case (root_clock_select[3:2])
            2'h1:    synth_input_clock = bclk_rise;
            2'h2:    synth_input_clock = gpio_rise;
            default: synth_input_clock = mclk_rise;
        endcase
        pll_r    = (pll_enable_predivide_multiply[3:0] == 4'h0) ? 5'd16
                   : {1'b0, pll_enable_predivide_multiply[3:0]};
        pll_p    = (pll_enable_predivide_multiply[6:4] == 3'h0) ? 4'd8
                   : {1'b0, pll_enable_predivide_multiply[6:4]};
        pll_frac = {pll_fraction_high[5:0], pll_fraction_low};
        pll_gain = 32'(pll_r) * (32'(pll_integer_part[5:0]) * `ACPL_FRAC_SCALE
                   + 32'(pll_frac));
        pll_cost = 32'(pll_p) * `ACPL_FRAC_SCALE;
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pll_credit <= 32'h0000_0000;
            pll_tick   <= 1'b0;
        end else if (!pll_enable_predivide_multiply[`ACPL_BIT_ENABLE]) begin
            pll_credit <= 32'h0000_0000;
            pll_tick   <= 1'b0;
        end else if (pll_credit >= pll_cost) begin
            pll_credit <= pll_credit - pll_cost + (synth_input_clock ? pll_gain : 32'h0000_0000);
            pll_tick   <= 1'b1;
        end else begin
            pll_credit <= pll_credit + (synth_input_clock ? pll_gain : 32'h0000_0000);
            pll_tick   <= 1'b0;
        end
    end
    logic root_tick;
    always_comb begin
        case (acpl_root_e'(root_clock_select[1:0]))
            ACPL_ROOT_MCLK: root_tick = mclk_rise;
            ACPL_ROOT_BCLK: root_tick = bclk_rise;
            ACPL_ROOT_GPIO: root_tick = gpio_rise;
            ACPL_ROOT_PLL:  root_tick = pll_tick;
            default:        root_tick = 1'b0;
        endcase
    end
    logic [ND-1:0]   div_src, div_en, div_tick, div_lvl;
    logic [DIVW-1:0] div_ratio [ND];
    logic [DIVW-1:0] div_cnt   [ND];
    logic            gp_src;

    function automatic logic [DIVW-1:0] ratio7(input logic [6:0] f);
        ratio7 = (f == 7'h00) ? DIVW'(128) : DIVW'(f);
    endfunction

    always_comb begin
        div_ratio[0] = ratio7(dac_predivider_ctrl[6:0]);
        div_ratio[1] = ratio7(modulator_divider_ctrl[6:0]);
        div_ratio[2] = ({oversampling_ratio_high[1:0], oversampling_ratio_low} == 10'h000)
                       ? DIVW'(1024)
                       : DIVW'({oversampling_ratio_high[1:0], oversampling_ratio_low});
        div_ratio[3] = ratio7(bit_clock_divider[6:0]);
        div_ratio[4] = ratio7(gp_clock_divider[6:0]);
        div_src[0] = root_tick;
        div_src[1] = div_tick[0];
        div_src[2] = div_tick[1];
        div_src[3] = (bclk_source_select[1:0] == 2'h1) ? div_tick[1] : div_tick[0];
        case (gp_clock_source_select[2:0])
            3'h0:    gp_src = mclk_rise;
            3'h1:    gp_src = bclk_rise;
            3'h3:    gp_src = pll_tick;
            3'h4:    gp_src = div_tick[0];
            3'h5:    gp_src = div_tick[1];
            3'h6:    gp_src = div_tick[2];
            default: gp_src = root_tick;
        endcase
        div_src[4] = gp_src;
        div_en[0]  = dac_predivider_ctrl[`ACPL_BIT_ENABLE];
        div_en[1]  = modulator_divider_ctrl[`ACPL_BIT_ENABLE];
        div_en[2]  = modulator_divider_ctrl[`ACPL_BIT_ENABLE];
        div_en[3]  = audio_if_ctrl[`ACPL_BIT_BCLK_DRIVE];
        div_en[4]  = gp_clock_source_select[`ACPL_BIT_GP_DRIVE];
    end

    // a ratio of one leaves the level output low; only the pulse is usable then
    for (genvar i = 0; i < ND; i++) begin : g_div
        always_ff @(posedge ref_clk or posedge reset) begin
            if (reset) begin
                div_cnt[i]  <= '0;
                div_tick[i] <= 1'b0;
                div_lvl[i]  <= 1'b0;
            end else if (!div_en[i]) begin
                div_cnt[i]  <= '0;
                div_tick[i] <= 1'b0;
                div_lvl[i]  <= 1'b0;
            end else if (div_src[i]) begin
                div_tick[i] <= (div_cnt[i] == div_ratio[i] - DIVW'(1));
                div_cnt[i]  <= (div_cnt[i] >= div_ratio[i] - DIVW'(1)) ? '0
                               : div_cnt[i] + DIVW'(1);
                div_lvl[i]  <= (div_cnt[i] < (div_ratio[i] >> 1));
            end else begin
                div_tick[i] <= 1'b0;
            end
        end
    end
    // dividers must keep running while draining, else the count never ends
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            pwr_state <= ACPL_PWR_OFF;
            drain_cnt <= 10'h000;
        end else begin
            case (pwr_state)
                ACPL_PWR_OFF: begin
                    drain_cnt <= 10'h000;
                    if (dac_power_ctrl[0] && div_en[0] && div_en[1]) begin
                        pwr_state <= ACPL_PWR_ON;
                    end
                end
                ACPL_PWR_ON: begin
                    drain_cnt <= 10'h000;
                    if (!dac_power_ctrl[0]) begin
                        pwr_state <= ACPL_PWR_DRAIN;
                    end
                end
                ACPL_PWR_DRAIN: begin
                    if (div_tick[1]) begin
                        drain_cnt <= drain_cnt + 10'h001;
                    end
                    if (drain_cnt == `ACPL_DRAIN_TICKS) begin
                        pwr_state <= ACPL_PWR_OFF;
                    end
                end
                default: pwr_state <= ACPL_PWR_OFF;
            endcase
        end
    end

    always_comb begin
        pwr_status = 8'h00;
        pwr_status[`ACPL_BIT_STAT_DAC] = (pwr_state != ACPL_PWR_OFF);
        pwr_status[`ACPL_BIT_STAT_MOD] = (pwr_state == ACPL_PWR_ON)
            || (pwr_state == ACPL_PWR_DRAIN && drain_cnt < (`ACPL_DRAIN_TICKS >> 1));
    end
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            bclk_out                <= 1'b0;
            bclk_oe_n               <= 1'b1;
            general_io_pin_one_out  <= 1'b0;
            general_io_pin_one_oe_n <= 1'b1;
            root_audio_tick         <= 1'b0;
            modulator_clock_tick    <= 1'b0;
            sample_rate_tick        <= 1'b0;
            dac_powered             <= 1'b0;
        end else begin
            bclk_out                <= div_lvl[3];
            bclk_oe_n               <= !audio_if_ctrl[`ACPL_BIT_BCLK_DRIVE];
            general_io_pin_one_out  <= div_lvl[4];
            general_io_pin_one_oe_n <= !gp_clock_source_select[`ACPL_BIT_GP_DRIVE];
            root_audio_tick         <= root_tick;
            modulator_clock_tick    <= div_tick[1];
            sample_rate_tick        <= div_tick[2];
            dac_powered             <= (pwr_state != ACPL_PWR_OFF);
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    a_pll_stopped: assert property (
        !pll_enable_predivide_multiply[`ACPL_BIT_ENABLE] |=> !pll_tick)
        else $error("synth ticks while disabled");
    a_prediv_gate: assert property (!div_en[0] |=> !div_tick[0])
        else $error("predivider ticks while disabled");
    a_mod_from_pre: assert property (div_tick[1] |-> $past(div_tick[0]))
        else $error("modulator tick without predivider tick");
    a_rate_from_mod: assert property (div_tick[2] |-> $past(div_tick[1]))
        else $error("rate tick without modulator tick");
    a_bclk_drive: assert property (
        $rose(audio_if_ctrl[`ACPL_BIT_BCLK_DRIVE]) |=> !bclk_oe_n)
        else $error("bit clock pin not driven after enable");
    a_frac_hold: assert property (
        wr_en && idx == `ACPL_IDX_PLL_FRAC_HI |=> $stable(pll_fraction_high))
        else $error("fraction high applied before low write");
    a_drain_flag: assert property (
        pwr_state == ACPL_PWR_ON && !dac_power_ctrl[0]
        |=> pwr_status[`ACPL_BIT_STAT_DAC] [*2])
        else $error("power flag dropped at drain start");
    a_zero_ratio: assert property (
        dac_predivider_ctrl[6:0] == 7'h00 |-> div_ratio[0] == DIVW'(128))
        else $error("zero divider field not 128");
    a_gp_idle: assert property (
        !gp_clock_source_select[`ACPL_BIT_GP_DRIVE] |=> ##1 !general_io_pin_one_out)
        else $error("general clock runs while disabled");
endmodule // acpl_clock_tree
`default_nettype wire

// *** acpl_ref_src.sv ***
// reference clock sources that drive the clock pins of the audio clock tree
`timescale 1ns/1ps
`default_nettype none
module acpl_ref_src #(
    parameter realtime HALF = 230.0
) (
    // reference pins
    output logic mclk,
    output logic bclk,
    output logic gpio
);
    initial begin
        mclk = 1'b0;
        bclk = 1'b0;
        gpio = 1'b0;
    end
    // free running and phase-unrelated to ref_clk, so the pin synchronisers see real skew
    always #(HALF) mclk = ~mclk;
    always #(HALF * 1.5) bclk = ~bclk;
    always #(HALF * 2.0) gpio = ~gpio;
endmodule // acpl_ref_src
`default_nettype wire

// *** tb.sv ***
// self-checking bench of the audio clock tree driven over apb
`timescale 1ns/1ps
`default_nettype none
module tb;
    import acpl_pkg::*;
    logic        ref_clk = 1'b0;
    logic        reset   = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h000;
    logic [31:0] pwdata  = 32'h0000_0000;
    logic [31:0] prdata;
    logic        pready, pslverr, bo, bo_n, go, go_n, sm, sb, sg, rt, mt, st, pwr;
    logic [9:0]  expq[$];
    logic [7:0]  r;
    int          n_errors = 0;
    int          compares = 0;
    int          n_root   = 0;
    int          n_mod    = 0;
    int          n_smp    = 0;
    int          n_bck    = 0;
    int          n_gpc    = 0;
    int          n_mck    = 0;
    int          d_root, d_mod, m0, d_bck, d_gpc, d_mck;

    acpl_ref_src u_acpl_ref_src (.mclk(sm), .bclk(sb), .gpio(sg));
    acpl_clock_tree u_acpl_clock_tree (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .mclk_pin(sm), .bclk_in(bo_n ? sb : bo), .bclk_out(bo), .bclk_oe_n(bo_n),
        .general_io_pin_one_in(go_n ? sg : go), .general_io_pin_one_out(go),
        .general_io_pin_one_oe_n(go_n), .root_audio_tick(rt), .modulator_clock_tick(mt),
        .sample_rate_tick(st), .dac_powered(pwr));

    always #50 ref_clk = ~ref_clk;

    // rising edges of the driven pins and of the reference pin
    always @(posedge bo) n_bck++;
    always @(posedge go) n_gpc++;
    always @(posedge sm) n_mck++;

    always @(posedge ref_clk) begin
        n_root <= n_root + ((rt === 1'b1) ? 1 : 0);
        n_mod  <= n_mod + ((mt === 1'b1) ? 1 : 0);
        n_smp  <= n_smp + ((st === 1'b1) ? 1 : 0);
    end

    task automatic results;
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask

    // oldest note is matched to the transfer that completes
    always @(posedge ref_clk) begin
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            chk("pslverr", {31'h0, expq[0][8]}, {31'h0, pslverr});
            if (expq[0][9]) begin
                chk("prdata", {24'h0, expq[0][7:0]}, prdata);
            end
            void'(expq.pop_front());
        end
    end

    // for a read, d is the expected data
    task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d, input logic e);
        int n;
        expq.push_back({~w, e, d});
        @(posedge ref_clk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'b00, idx, 2'b00};
        pwdata  <= {24'h0, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            n_errors++;
            results();
        end
    endtask

    // waits k periods of the modulator (sel 0) or sample clock (sel 1), counting parents
    task automatic span(input logic sel, input int k);
        int c, r0, mm, n, b0, g0, k0;
        n = 0;
        c = sel ? n_smp : n_mod;
        while ((sel ? n_smp : n_mod) == c && n < 9000) begin
            @(posedge ref_clk);
            n++;
        end
        r0 = n_root;
        mm = n_mod;
        b0 = n_bck;
        g0 = n_gpc;
        k0 = n_mck;
        c  = sel ? n_smp : n_mod;
        while ((sel ? n_smp : n_mod) < c + k && n < 9000) begin
            @(posedge ref_clk);
            n++;
        end
        if (n >= 9000) begin
            n_errors++;
            results();
        end
        d_root = n_root - r0;
        d_mod  = n_mod - mm;
        d_bck  = n_bck - b0;
        d_gpc  = n_gpc - g0;
        d_mck  = n_mck - k0;
    endtask

    initial begin
        void'($urandom(60));
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        apb(1'b0, 8'h05, 8'h11, 1'b0);
        apb(1'b0, 8'h06, 8'h04, 1'b0);
        apb(1'b0, 8'h0e, 8'h80, 1'b0);
        apb(1'b0, 8'h30, 8'h00, 1'b1);
        apb(1'b1, 8'h25, 8'hff, 1'b0);
        apb(1'b0, 8'h25, 8'h00, 1'b0);
        r = 8'($urandom_range(63, 1));
        apb(1'b1, 8'h06, r, 1'b0);
        apb(1'b0, 8'h06, r, 1'b0);
        apb(1'b1, 8'h07, 8'h27, 1'b0);
        apb(1'b1, 8'h08, 8'h0f, 1'b0);
        apb(1'b0, 8'h07, 8'h27, 1'b0);
        apb(1'b1, 8'h04, 8'h00, 1'b0);
        apb(1'b1, 8'h0b, 8'h82, 1'b0);
        apb(1'b1, 8'h0c, 8'h83, 1'b0);
        apb(1'b1, 8'h0d, 8'h00, 1'b0);
        apb(1'b1, 8'h0e, 8'h04, 1'b0);
        span(1'b0, 4);
        chk("root per modulator", 32'h0000_0018, d_root);
        span(1'b1, 2);
        chk("modulator per sample", 32'h0000_0008, d_mod);
        apb(1'b1, 8'h40, 8'h01, 1'b0);
        apb(1'b0, 8'h25, 8'h88, 1'b0);
        chk("dac_powered", 32'h0000_0001, {31'h0, pwr});
        apb(1'b1, 8'h40, 8'h00, 1'b0);
        apb(1'b0, 8'h25, 8'h88, 1'b0);
        span(1'b0, 70);
        apb(1'b0, 8'h25, 8'h00, 1'b0);
        apb(1'b1, 8'h0b, 8'h80, 1'b0);
        apb(1'b1, 8'h0c, 8'h81, 1'b0);
        span(1'b0, 2);
        chk("root per modulator", 32'h0000_0100, d_root);
        apb(1'b1, 8'h0c, 8'h01, 1'b0);
        apb(1'b1, 8'h0b, 8'h00, 1'b0);
        repeat (20) @(posedge ref_clk);
        m0 = n_mod;
        repeat (300) @(posedge ref_clk);
        chk("modulator stopped", 32'h0000_0000, n_mod - m0);
        // input/P stays below 10 MHz here, so the fraction must be zero
        apb(1'b1, 8'h07, 8'h00, 1'b0);
        apb(1'b1, 8'h08, 8'h00, 1'b0);
        apb(1'b1, 8'h06, 8'h04, 1'b0);
        apb(1'b1, 8'h05, 8'ha2, 1'b0);
        apb(1'b1, 8'h04, 8'h03, 1'b0);
        apb(1'b1, 8'h0b, 8'h90, 1'b0);
        apb(1'b1, 8'h0c, 8'h81, 1'b0);
        span(1'b0, 8);
        // mclk is counted at the pin, so either end of the span may slip by one edge
        chk("synth gain", 32'h0000_0004, (d_mck + 4) / 8);
        apb(1'b1, 8'h04, 8'h00, 1'b0);
        apb(1'b1, 8'h05, 8'h11, 1'b0);
        apb(1'b1, 8'h0b, 8'h82, 1'b0);
        apb(1'b1, 8'h0c, 8'h84, 1'b0);
        apb(1'b1, 8'h1b, 8'h08, 1'b0);
        apb(1'b1, 8'h1e, 8'h02, 1'b0);
        apb(1'b1, 8'h19, 8'h85, 1'b0);
        apb(1'b1, 8'h1a, 8'h02, 1'b0);
        span(1'b0, 8);
        chk("bclk rises", 32'h0000_0010, d_bck);
        chk("gp rises", 32'h0000_0004, d_gpc);
        chk("bclk_oe_n", 32'h0000_0000, {31'h0, bo_n});
        chk("gp_oe_n", 32'h0000_0000, {31'h0, go_n});
        apb(1'b1, 8'h1d, 8'h01, 1'b0);
        span(1'b0, 8);
        chk("bclk rises", 32'h0000_0004, d_bck);
        results();
    end
endmodule // tb
`default_nettype wire
